/* common/inband_pkg.sv */
// constants, field layouts and carriers of the inband loopback block
// assumes one 40 MHz system clock and a 32-bit classic wishbone bus
package inband_pkg;

  // ============================================================
  // timing
  localparam int unsigned SYS_CLK_HZ = 40_000_000;
  localparam real PERSIST_TIME_S = 5.1;
  localparam int unsigned PERSIST_CYCLES =
    int'($ceil(PERSIST_TIME_S * SYS_CLK_HZ));
  localparam int TIMER_W = 28;

  // ============================================================
  // code geometry
  localparam int CODE_W = 8;
  localparam int LEN_W = 2;
  localparam int PTR_W = 3;
  // top bit index of a 5-bit code; each length step adds one
  localparam logic [PTR_W-1:0] CODE_TOP_BASE = 3'h4;
  localparam logic [PTR_W-1:0] CODE_TOP_MAX = 3'h7;
  localparam logic [CODE_W-1:0] CODE_ALL_ONES = 8'hff;

  // ============================================================
  // register indices, byte address is four times the index
  localparam int IDX_W = 6;
  localparam logic [IDX_W-1:0] IDX_PATTERN_CTRL = 6'h10;
  localparam logic [IDX_W-1:0] IDX_DETECT_CTRL = 6'h11;
  localparam logic [IDX_W-1:0] IDX_LEN_CTRL = 6'h15;
  localparam logic [IDX_W-1:0] IDX_GEN_CODE = 6'h16;
  localparam logic [IDX_W-1:0] IDX_ACT_CODE = 6'h17;
  localparam logic [IDX_W-1:0] IDX_DEACT_CODE = 6'h18;
  localparam logic [IDX_W-1:0] IDX_LOOP_CTRL = 6'h19;
  localparam logic [IDX_W-1:0] IDX_EDGE_SEL = 6'h1a;
  localparam logic [IDX_W-1:0] IDX_LIVE_STATUS = 6'h1c;
  localparam logic [IDX_W-1:0] IDX_INT_STATUS = 6'h1d;
  localparam logic [IDX_W-1:0] IDX_INT_MASK = 6'h1e;

  // ============================================================
  // field positions
  localparam int GEN_LEN_LSB = 4;
  localparam int ACT_LEN_LSB = 2;
  localparam int DEACT_LEN_LSB = 0;
  localparam int LOOP_AUTO_BIT = 3;
  localparam int LOOP_DIGITAL_BIT = 2;
  localparam int LOOP_REMOTE_BIT = 1;
  localparam int LOOP_ANALOG_BIT = 0;
  localparam int PATSEL_LSB = 4;
  localparam int GEN_DIR_BIT = 3;
  localparam int DET_DIR_BIT = 3;
  localparam int EDGE_SEL_BIT = 0;
  localparam int STAT_ACT_BIT = 1;
  localparam int STAT_DEACT_BIT = 0;

  // ============================================================
  // reset values and writable bits
  localparam logic [7:0] LEN_RST = 8'h01;
  localparam logic [7:0] GEN_RST = 8'h01;
  localparam logic [7:0] ACT_RST = 8'h01;
  localparam logic [7:0] DEACT_RST = 8'h09;
  localparam logic [7:0] LOOP_RST = 8'h00;
  localparam logic [7:0] PATTERN_RST = 8'h00;
  localparam logic [7:0] DETECT_RST = 8'h03;
  localparam logic [7:0] EDGE_RST = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h3;
  localparam logic [7:0] LEN_WMASK = 8'h3f;
  localparam logic [7:0] LOOP_WMASK = 8'h0f;
  localparam logic [7:0] PATTERN_WMASK = 8'h38;
  localparam logic [7:0] DETECT_WMASK = 8'h0f;
  localparam logic [7:0] EDGE_WMASK = 8'h01;

  // pattern select values
  localparam logic [1:0] PATSEL_OFF = 2'h0;
  localparam logic [1:0] PATSEL_PRBS = 2'h1;
  localparam logic [1:0] PATSEL_ARB = 2'h2;
  localparam logic [1:0] PATSEL_INBAND = 2'h3;

  // ============================================================
  // carriers
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_s;

  typedef struct packed {
    logic clk;
    logic data;
  } line_bit_s;

  typedef struct packed {
    logic strobe;
    logic data;
  } insert_s;

  typedef struct packed {
    logic digital;
    logic remote;
    logic analog;
  } loop_ctrl_s;

endpackage

/* hdl/inband_code_gen.sv */
// repeating inband code generator, one bit per step
// assumes step is a one-cycle enable on sys_clk
`timescale 1ns/10ps
module inband_code_gen (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic step,
  input wire logic [inband_pkg::CODE_W-1:0] code,
  input wire logic [inband_pkg::LEN_W-1:0] len,
  output logic curBit
);
  import inband_pkg::*;

  logic [PTR_W-1:0] topIdx;
  logic [PTR_W-1:0] ptrQ;

  assign topIdx = CODE_TOP_BASE + {1'b0, len};
  assign curBit = code[ptrQ];

  // highest valid bit first, wraps back to back
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptrQ <= CODE_TOP_BASE;
    end else if (!enable) begin
      ptrQ <= topIdx;
    end else if (step) begin
      ptrQ <= (ptrQ == '0) ? topIdx : ptrQ - 1'b1;
    end
  end
endmodule

/* hdl/inband_code_detect.sv */
// inband code detector with persistence timer
// assumes bitStrobe is a one-cycle enable on sys_clk
`timescale 1ns/10ps
module inband_code_detect #(
  parameter int unsigned PERSIST_LIMIT = inband_pkg::PERSIST_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic bitStrobe,
  input wire logic bitData,
  input wire logic [inband_pkg::CODE_W-1:0] code,
  input wire logic [inband_pkg::LEN_W-1:0] len,
  output logic present,
  output logic persisted
);
  import inband_pkg::*;

  localparam logic [TIMER_W-1:0] LIMIT = TIMER_W'(PERSIST_LIMIT);

  logic [CODE_W-1:0] histQ;
  logic [CODE_W-1:0] histD;
  logic [CODE_W-1:0] validMask;
  logic [PTR_W-1:0] topIdx;
  logic [PTR_W-1:0] phaseQ;
  logic lockedQ;
  logic persistQ;
  logic windowHit;
  logic [TIMER_W-1:0] timerQ;

  assign topIdx = CODE_TOP_BASE + {1'b0, len};
  assign validMask = CODE_ALL_ONES >> (CODE_TOP_MAX - topIdx);
  assign histD = {histQ[CODE_W-2:0], bitData};
  // newest bit sits at bit 0, so code bit 0 is the last to arrive
  assign windowHit = ((histD ^ code) & validMask) == '0;
  assign present = lockedQ;
  assign persisted = persistQ;

  // ============================================================
  // lock and follow the repeating code
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      histQ <= '0;
      lockedQ <= 1'b0;
      phaseQ <= CODE_TOP_BASE;
    end else if (bitStrobe) begin
      histQ <= histD;
      if (lockedQ) begin
        if (bitData != code[phaseQ]) begin
          lockedQ <= 1'b0;
        end
        phaseQ <= (phaseQ == '0) ? topIdx : phaseQ - 1'b1;
      end else if (windowHit) begin
        lockedQ <= 1'b1;
        phaseQ <= topIdx;
      end
    end
  end

  // ============================================================
  // persistence, strictly longer than the limit
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      timerQ <= '0;
      persistQ <= 1'b0;
    end else if (!lockedQ) begin
      timerQ <= '0;
      persistQ <= 1'b0;
    end else if (timerQ < LIMIT) begin
      timerQ <= timerQ + 1'b1;
    end else begin
      persistQ <= 1'b1;
    end
  end
endmodule

/* hdl/inband_loopback_top.sv */
// per-channel inband loopback control: registers, code generator,
// activate and deactivate detectors and loopback selection
// assumes line clocks and data arrive asynchronously on pins and
// a classic wishbone master on sys_clk
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/10ps

// Overview of operation
// - generation length field picks 5 to 8 low code bits, reset 00
// - activate length field picks 5 to 8 low bits, reset 00
// - deactivate length field picks 5 to 8 low bits, reset 01
// - generated code goes out highest valid bit first, bit 0 last
// - generated code repeats back to back until generation stops
// - activate code matched with bit 0 as the last received bit
// - deactivate code matched with bit 0 as the last received bit
// - auto mode: activate held over 5.1 s enters digital/remote loop
// - auto mode: deactivate held over 5.1 s leaves that loopback
// - auto enable at bit 3, reset 0; off means codes change no loopback bit
// - bit 2 enables digital loopback, reset 0
// - bit 1 enables remote loopback, reset 0
// - bit 0 enables analog loopback, reset 0
// - deactivate code resets to 09, generate and activate to 01
// - generation runs only when pattern select is 11
// - generation direction: 0 transmit path, 1 receive path
// - detection direction: 0 receive path, 1 transmit path
// - detect flags set on rising edge, or either edge when selected
module inband_loopback_top #(
  parameter int unsigned PERSIST_LIMIT = inband_pkg::PERSIST_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire inband_pkg::wb_req_s wbReq,
  output inband_pkg::wb_rsp_s wbRsp,
  input wire inband_pkg::line_bit_s txLine,
  input wire inband_pkg::line_bit_s rxLine,
  output inband_pkg::insert_s txInsert,
  output inband_pkg::insert_s rxInsert,
  output inband_pkg::loop_ctrl_s loopCtrl,
  output logic irq
);
  import inband_pkg::*;

  // ============================================================
  // registers
  logic [7:0] lenCtrlQ;
  logic [7:0] genCodeQ;
  logic [7:0] actCodeQ;
  logic [7:0] deactCodeQ;
  logic [7:0] loopQ;
  logic [7:0] patternQ;
  logic [7:0] detectQ;
  logic [7:0] edgeSelQ;
  logic [1:0] intStatQ;
  logic [1:0] intMaskQ;

  // ============================================================
  // bus signals
  logic ackQ;
  logic [31:0] rdDataQ;
  logic [31:0] rdData;
  logic busHit;
  logic wrEn;
  logic [IDX_W-1:0] regIdx;
  logic [7:0] wrByte;

  // ============================================================
  // line side signals
  logic [3:0] syncAQ;
  logic [3:0] syncBQ;
  logic txClkPrevQ;
  logic rxClkPrevQ;
  logic txEdge;
  logic rxEdge;
  logic txBit;
  logic rxBit;

  // ============================================================
  // engine signals
  logic genActive;
  logic genToRx;
  logic genStep;
  logic genBit;
  logic detOnTx;
  logic detStrobe;
  logic detData;
  logic actPresent;
  logic deactPresent;
  logic actPersist;
  logic deactPersist;
  logic actPrevQ;
  logic deactPrevQ;
  logic actPersistPrevQ;
  logic deactPersistPrevQ;
  logic actFire;
  logic deactFire;
  logic actEvent;
  logic deactEvent;
  logic edgeAny;
  logic autoEn;
  logic [1:0] intSet;
  logic [1:0] intClr;
  insert_s txInsertQ;
  insert_s rxInsertQ;
  logic irqQ;

  // ============================================================
  // wishbone slave, one wait state, unmapped reads give zero
  assign busHit = wbReq.cyc & wbReq.stb & ~ackQ;
  assign wrEn = busHit & wbReq.we & wbReq.sel[0];
  assign regIdx = wbReq.adr[IDX_W+1:2];
  assign wrByte = wbReq.dat[7:0];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= busHit;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdDataQ <= '0;
    end else if (busHit & ~wbReq.we) begin
      rdDataQ <= rdData;
    end
  end

  always_comb begin
    rdData = '0;
    case (regIdx)
      IDX_PATTERN_CTRL: begin
        rdData[7:0] = patternQ;
      end
      IDX_DETECT_CTRL: begin
        rdData[7:0] = detectQ;
      end
      IDX_LEN_CTRL: begin
        rdData[7:0] = lenCtrlQ;
      end
      IDX_GEN_CODE: begin
        rdData[7:0] = genCodeQ;
      end
      IDX_ACT_CODE: begin
        rdData[7:0] = actCodeQ;
      end
      IDX_DEACT_CODE: begin
        rdData[7:0] = deactCodeQ;
      end
      IDX_LOOP_CTRL: begin
        rdData[7:0] = loopQ;
      end
      IDX_EDGE_SEL: begin
        rdData[7:0] = edgeSelQ;
      end
      IDX_LIVE_STATUS: begin
        rdData[STAT_ACT_BIT] = actPrevQ;
        rdData[STAT_DEACT_BIT] = deactPrevQ;
      end
      IDX_INT_STATUS: begin
        rdData[1:0] = intStatQ;
      end
      IDX_INT_MASK: begin
        rdData[1:0] = intMaskQ;
      end
      default: begin
        rdData = '0;
      end
    endcase
  end

  assign wbRsp = '{ack: ackQ, dat: rdDataQ};

  // ============================================================
  // configuration registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lenCtrlQ <= LEN_RST;
    end else if (wrEn && regIdx == IDX_LEN_CTRL) begin
      lenCtrlQ <= wrByte & LEN_WMASK;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      genCodeQ <= GEN_RST;
      actCodeQ <= ACT_RST;
      deactCodeQ <= DEACT_RST;
    end else if (wrEn) begin
      if (regIdx == IDX_GEN_CODE) begin
        genCodeQ <= wrByte;
      end
      if (regIdx == IDX_ACT_CODE) begin
        actCodeQ <= wrByte;
      end
      if (regIdx == IDX_DEACT_CODE) begin
        deactCodeQ <= wrByte;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      patternQ <= PATTERN_RST;
      detectQ <= DETECT_RST;
      edgeSelQ <= EDGE_RST;
    end else if (wrEn) begin
      if (regIdx == IDX_PATTERN_CTRL) begin
        patternQ <= wrByte & PATTERN_WMASK;
      end
      if (regIdx == IDX_DETECT_CTRL) begin
        detectQ <= wrByte & DETECT_WMASK;
      end
      if (regIdx == IDX_EDGE_SEL) begin
        edgeSelQ <= wrByte & EDGE_WMASK;
      end
    end
  end

  // ============================================================
  // loopback control, hardware events win over a same-cycle write
  assign autoEn = loopQ[LOOP_AUTO_BIT];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      loopQ <= LOOP_RST;
    end else begin
      if (wrEn && regIdx == IDX_LOOP_CTRL) begin
        loopQ <= wrByte & LOOP_WMASK;
      end
      if (autoEn && actFire) begin
        if (detOnTx) begin
          loopQ[LOOP_DIGITAL_BIT] <= 1'b1;
        end else begin
          loopQ[LOOP_REMOTE_BIT] <= 1'b1;
        end
      end
      if (autoEn && deactFire) begin
        if (detOnTx) begin
          loopQ[LOOP_DIGITAL_BIT] <= 1'b0;
        end else begin
          loopQ[LOOP_REMOTE_BIT] <= 1'b0;
        end
      end
    end
  end

  assign loopCtrl = '{
    digital: loopQ[LOOP_DIGITAL_BIT],
    remote: loopQ[LOOP_REMOTE_BIT],
    analog: loopQ[LOOP_ANALOG_BIT]
  };

  // ============================================================
  // pin synchronisers; stage A feeds only stage B
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncAQ <= '0;
      syncBQ <= '0;
    end else begin
      syncAQ <= {txLine.clk, txLine.data, rxLine.clk, rxLine.data};
      syncBQ <= syncAQ;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txClkPrevQ <= 1'b0;
      rxClkPrevQ <= 1'b0;
    end else begin
      txClkPrevQ <= syncBQ[3];
      rxClkPrevQ <= syncBQ[1];
    end
  end

  // line clocks are far slower than sys_clk, so a rising edge of the
  // synchronised clock is one bit; data travels the same two stages
  assign txEdge = syncBQ[3] & ~txClkPrevQ;
  assign rxEdge = syncBQ[1] & ~rxClkPrevQ;
  assign txBit = syncBQ[2];
  assign rxBit = syncBQ[0];

  // ============================================================
  // generator
  assign genActive =
    patternQ[PATSEL_LSB+:2] == PATSEL_INBAND;
  assign genToRx = patternQ[GEN_DIR_BIT];
  assign genStep = genToRx ? rxEdge : txEdge;

  inband_code_gen genUnit (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .enable(genActive),
    .step(genStep),
    .code(genCodeQ),
    .len(lenCtrlQ[GEN_LEN_LSB+:LEN_W]),
    .curBit(genBit)
  );

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txInsertQ <= '0;
      rxInsertQ <= '0;
    end else begin
      txInsertQ.strobe <= genActive & ~genToRx & txEdge;
      rxInsertQ.strobe <= genActive & genToRx & rxEdge;
      if (genStep) begin
        txInsertQ.data <= genBit & ~genToRx;
        rxInsertQ.data <= genBit & genToRx;
      end
    end
  end

  assign txInsert = txInsertQ;
  assign rxInsert = rxInsertQ;

  // ============================================================
  // detectors share one tap so both codes watch the same path
  assign detOnTx = detectQ[DET_DIR_BIT];
  assign detStrobe = detOnTx ? txEdge : rxEdge;
  assign detData = detOnTx ? txBit : rxBit;

  inband_code_detect #(
    .PERSIST_LIMIT(PERSIST_LIMIT)
  ) actUnit (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .bitStrobe(detStrobe),
    .bitData(detData),
    .code(actCodeQ),
    .len(lenCtrlQ[ACT_LEN_LSB+:LEN_W]),
    .present(actPresent),
    .persisted(actPersist)
  );

  inband_code_detect #(
    .PERSIST_LIMIT(PERSIST_LIMIT)
  ) deactUnit (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .bitStrobe(detStrobe),
    .bitData(detData),
    .code(deactCodeQ),
    .len(lenCtrlQ[DEACT_LEN_LSB+:LEN_W]),
    .present(deactPresent),
    .persisted(deactPersist)
  );

  // ============================================================
  // detected status, edge events and persistence firing
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      actPrevQ <= 1'b0;
      deactPrevQ <= 1'b0;
      actPersistPrevQ <= 1'b0;
      deactPersistPrevQ <= 1'b0;
    end else begin
      actPrevQ <= actPresent;
      deactPrevQ <= deactPresent;
      actPersistPrevQ <= actPersist;
      deactPersistPrevQ <= deactPersist;
    end
  end

  assign actFire = actPersist & ~actPersistPrevQ;
  assign deactFire = deactPersist & ~deactPersistPrevQ;
  assign edgeAny = edgeSelQ[EDGE_SEL_BIT];
  assign actEvent = edgeAny ? (actPresent ^ actPrevQ)
                            : (actPresent & ~actPrevQ);
  assign deactEvent = edgeAny ? (deactPresent ^ deactPrevQ)
                              : (deactPresent & ~deactPrevQ);

  // ============================================================
  // interrupt flags, write one to clear, a new event beats the clear
  always_comb begin
    intSet = '0;
    intSet[STAT_ACT_BIT] = actEvent;
    intSet[STAT_DEACT_BIT] = deactEvent;
    intClr = '0;
    if (wrEn && regIdx == IDX_INT_STATUS) begin
      intClr = wrByte[1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      intStatQ <= '0;
    end else begin
      intStatQ <= (intStatQ & ~intClr) | intSet;
    end
  end

  // mask bit 1 keeps the matching flag off irq; the flag itself still sets
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      intMaskQ <= MASK_RST;
    end else if (wrEn && regIdx == IDX_INT_MASK) begin
      intMaskQ <= wrByte[1:0];
    end
  end

  // irq lags the flag by one cycle so the pin comes from a flop
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqQ <= 1'b0;
    end else begin
      irqQ <= |(intStatQ & ~intMaskQ);
    end
  end

  assign irq = irqQ;
endmodule

/* sim/inband_loopback_props.sv */
// checker for the inband loopback top, watching its ports only
// assumes the register map of inband_pkg and the bind at the foot
`timescale 1ns/10ps
module inband_loopback_props #(
  parameter int unsigned PERSIST_LIMIT = inband_pkg::PERSIST_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire inband_pkg::wb_req_s wbReq,
  input wire inband_pkg::wb_rsp_s wbRsp,
  input wire inband_pkg::insert_s txInsert,
  input wire inband_pkg::insert_s rxInsert,
  input wire inband_pkg::loop_ctrl_s loopCtrl,
  input wire logic irq
);
  import inband_pkg::*;
  // ==========================================================
  // shadow fields, updated on the edge that takes the write
  logic take;
  logic wrEn;
  logic loopWr;
  logic autoQ;
  logic genOnQ;
  logic genDirQ;
  assign take = wbReq.cyc && wbReq.stb && !wbRsp.ack;
  assign wrEn = take && wbReq.we && wbReq.sel[0];
  assign loopWr = wrEn && wbReq.adr[7:2] == IDX_LOOP_CTRL;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      autoQ <= 1'b0;
    end else if (loopWr) begin
      autoQ <= wbReq.dat[LOOP_AUTO_BIT];
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      genOnQ <= 1'b0;
      genDirQ <= 1'b0;
    end else if (wrEn && wbReq.adr[7:2] == IDX_PATTERN_CTRL) begin
      genOnQ <= wbReq.dat[5:4] == PATSEL_INBAND;
      genDirQ <= wbReq.dat[GEN_DIR_BIT];
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  chk_ack_next: assert property (take |=> wbRsp.ack)
    else $error("no ack one cycle after request");
  chk_ack_pulse: assert property (wbRsp.ack |->
    wbRsp.dat[31:8] == 24'h0 ##1 !wbRsp.ack)
    else $error("ack too long or read data too wide");
  chk_dig_write: assert property (
    loopWr |=> loopCtrl.digital == $past(wbReq.dat[2]))
    else $error("digital loop not as written");
  chk_rem_write: assert property (
    loopWr |=> loopCtrl.remote == $past(wbReq.dat[1]))
    else $error("remote loop not as written");
  chk_ana_write: assert property (
    loopWr |=> loopCtrl.analog == $past(wbReq.dat[0]))
    else $error("analog loop not as written");
  chk_auto_off_hold: assert property (
    !autoQ && !loopWr |=> $stable(loopCtrl))
    else $error("loop state moved without auto mode");
  chk_gen_quiet: assert property (
    !genOnQ && !$past(genOnQ) |-> !txInsert.strobe && !rxInsert.strobe)
    else $error("code bit while generation off");
  chk_gen_path: assert property (
    txInsert.strobe || rxInsert.strobe |->
      rxInsert.strobe == genDirQ && txInsert.strobe != genDirQ)
    else $error("code bit on wrong path");
  cov_auto_remote: cover property (autoQ && $rose(loopCtrl.remote));
  cov_tx_bit: cover property (txInsert.strobe && txInsert.data);
  cov_irq: cover property ($rose(irq));
endmodule

bind inband_loopback_top inband_loopback_props #(
  .PERSIST_LIMIT(PERSIST_LIMIT)
) inband_loopback_props_i (
  .sys_clk(sys_clk), .reset_n(reset_n), .wbReq(wbReq), .wbRsp(wbRsp),
  .txInsert(txInsert), .rxInsert(rxInsert), .loopCtrl(loopCtrl),
  .irq(irq));

/* sim/line_partner.sv */
// far end of one line: sends a repeating code, top bit first
// assumes 5 MHz line rate; the clock stands low between frames
`timescale 1ns/10ps
module line_partner (
  input wire logic run,
  input wire logic [7:0] code,
  input wire logic [1:0] len,
  output inband_pkg::line_bit_s line
);
  import inband_pkg::*;
  int i;
  initial begin
    line = '0;
    forever begin
      if (!run) begin
        // idle data keeps moving so a stale bit is never trusted
        #100 line.data = ~line.data;
      end else begin
        for (i = 4 + len; i >= 0; i--) begin
          #50 line.data = code[i];
          #50 line.clk = 1'b1;
          #100 line.clk = 1'b0;
        end
      end
    end
  end
endmodule

/* sim/inband_loopback_code_control_bench.sv */
// self-checking bench for the inband loopback top
// assumes the bound checker and two line_partner models on the pins
`timescale 1ns/10ps
module inband_loopback_code_control_bench;
  import inband_pkg::*;
  logic sys_clk;
  logic reset_n;
  wb_req_s wbReq;
  wb_rsp_s wbRsp;
  line_bit_s txLine;
  line_bit_s rxLine;
  insert_s txInsert;
  insert_s rxInsert;
  loop_ctrl_s loopCtrl;
  logic irq;
  logic [3:0] watch;
  logic txRun;
  logic rxRun;
  logic [7:0] code;
  logic [1:0] len;
  int nErrors;
  int checkCount;
  assign watch = {loopCtrl, irq};
  // short persistence keeps the run small
  inband_loopback_top #(.PERSIST_LIMIT(20)) inband_loopback_top_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .wbReq(wbReq), .wbRsp(wbRsp),
    .txLine(txLine), .rxLine(rxLine), .txInsert(txInsert),
    .rxInsert(rxInsert), .loopCtrl(loopCtrl), .irq(irq));
  line_partner tx_side_i (.run(txRun), .code(code), .len(len),
    .line(txLine));
  line_partner rx_side_i (.run(rxRun), .code(code), .len(len),
    .line(rxLine));
  // ==========================================================
  // common tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (nErrors == 0 && checkCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic hang();
    nErrors++;
    end_of_test();
  endtask
  task automatic bus(input logic we, input logic [5:0] idx,
      input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    wbReq <= {2'h3, we, idx, 2'h0, 4'h1, 24'h0, wd};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 50);
    rd = wbRsp.dat[7:0];
    wbReq <= '0;
    if (n >= 50) begin
      hang();
    end
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] rd;
    bus(1'b1, idx, d, rd);
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [7:0] e);
    logic [7:0] rd;
    bus(1'b0, idx, 8'h00, rd);
    chk(rd, e);
  endtask
  task automatic drive(input logic [1:0] r, input logic [7:0] c,
      input logic [1:0] l);
    txRun <= r[1];
    rxRun <= r[0];
    code <= c;
    len <= l;
  endtask
  task automatic waitBit(input int b, input logic v);
    int n;
    for (n = 0; n < 2000 && watch[b] !== v; n++) begin
      @(posedge sys_clk);
    end
    if (watch[b] !== v) begin
      hang();
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic regsReset();
    logic [5:0] idx [6] = '{6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h3f};
    logic [7:0] e [6] = '{8'h01, 8'h01, 8'h01, 8'h09, 8'h00, 8'h00};
    wr(6'h3f, 8'h5a);
    foreach (idx[i]) begin
      rdc(idx[i], e[i]);
    end
  endtask
  task automatic loopBits();
    for (int i = 0; i < 8; i++) begin
      wr(IDX_LOOP_CTRL, 8'hf0 | 8'(i));
      chk({29'h0, loopCtrl}, 32'(i));
      rdc(IDX_LOOP_CTRL, 8'(i));
    end
  endtask
  task automatic genCode(input logic [1:0] l, input logic [7:0] c,
      input logic dir);
    int top;
    int n;
    int k;
    insert_s ins;
    top = 4 + l;
    wr(IDX_LEN_CTRL, {2'h0, l, 4'h1});
    wr(IDX_GEN_CODE, c);
    wr(IDX_PATTERN_CTRL, {2'h0, 2'h3, dir, 3'h0});
    drive({!dir, dir}, 8'h00, 2'h0);
    n = 0;
    k = 0;
    while (k < 2 * (top + 1) && n < 2000) begin
      @(posedge sys_clk);
      n++;
      ins = dir ? rxInsert : txInsert;
      if (ins.strobe === 1'b1) begin
        chk(ins.data, c[top - k % (top + 1)]);
        k++;
      end
    end
    if (n >= 2000) begin
      hang();
    end
    // only the inband selection may produce code bits
    for (int s = 0; s < 3; s++) begin
      wr(IDX_PATTERN_CTRL, {2'h0, 2'(s), dir, 3'h0});
      k = 0;
      repeat (100) begin
        @(posedge sys_clk);
        k += (txInsert.strobe === 1'b1 || rxInsert.strobe === 1'b1);
      end
      chk(k, 0);
    end
    drive(2'b00, 8'h00, 2'h0);
  endtask
  task automatic autoLoop();
    wr(IDX_LEN_CTRL, 8'h01);
    wr(IDX_LOOP_CTRL, 8'h08);
    drive(2'b01, 8'h01, 2'h0);
    waitBit(2, 1'b1);
    chk(watch, 4'b0100);
    rdc(IDX_LIVE_STATUS, 8'h02);
    drive(2'b01, 8'h09, 2'h1);
    waitBit(2, 1'b0);
    chk(watch, 4'b0000);
    wr(IDX_DETECT_CTRL, 8'h0b);
    drive(2'b10, 8'h01, 2'h0);
    waitBit(3, 1'b1);
    chk(watch, 4'b1000);
    wr(IDX_LOOP_CTRL, 8'h08);
    drive(2'b10, 8'h03, 2'h0);
    repeat (400) @(posedge sys_clk);
    chk(watch, 4'b0000);
    rdc(IDX_LIVE_STATUS, 8'h00);
    wr(IDX_LOOP_CTRL, 8'h00);
    drive(2'b10, 8'h01, 2'h0);
    repeat (400) @(posedge sys_clk);
    chk(watch, 4'b0000);
    drive(2'b00, 8'h01, 2'h0);
  endtask
  task automatic irqTest();
    wr(IDX_DETECT_CTRL, 8'h03);
    drive(2'b01, 8'h03, 2'h0);
    repeat (200) @(posedge sys_clk);
    wr(IDX_INT_STATUS, 8'h03);
    wr(IDX_INT_MASK, 8'h01);
    rdc(IDX_INT_STATUS, 8'h00);
    drive(2'b01, 8'h01, 2'h0);
    waitBit(0, 1'b1);
    rdc(IDX_INT_STATUS, 8'h02);
    wr(IDX_INT_MASK, 8'h03);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    wr(IDX_INT_STATUS, 8'h02);
    repeat (100) @(posedge sys_clk);
    rdc(IDX_INT_STATUS, 8'h00);
    wr(IDX_EDGE_SEL, 8'h01);
    drive(2'b01, 8'h03, 2'h0);
    repeat (200) @(posedge sys_clk);
    rdc(IDX_INT_STATUS, 8'h02);
    drive(2'b00, 8'h03, 2'h0);
  endtask
  // ==========================================================
  // clock, reset and sequence
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    reset_n = 1'b0;
    wbReq = '0;
    txRun = 1'b0;
    rxRun = 1'b0;
    code = 8'h00;
    len = 2'h0;
    nErrors = 0;
    checkCount = 0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    regsReset();
    loopBits();
    genCode(2'h0, 8'hf6, 1'b0);
    genCode(2'h3, 8'h4b, 1'b1);
    autoLoop();
    irqTest();
    end_of_test();
  end
endmodule
